// ===== logic/asrp_pkg.sv
package asrp_pkg;
   // ------------------------------------------------------------
   // result word and pin map of the shared data bus
   // ------------------------------------------------------------
   localparam int RESULT_BITS = 18;
   localparam int PINS = 18;
   localparam int FIFO_DEPTH = 32;
   localparam int CHAIN_DELAY = 16;
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   localparam int PIN_DIV0 = 4;
   localparam int PIN_DIV1 = 5;
   localparam int PIN_CLKSRC = 6;
   localparam int PIN_SYNCPOL = 7;
   localparam int PIN_INVCLK = 8;
   localparam int PIN_READ_SEL = 9;
   localparam int PIN_SERIAL_OUT = 10;
   localparam int PIN_SCLK = 11;
   localparam int PIN_SYNC = 12;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_FRAMES = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0101;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_QLEN_LSB = 8;
   localparam int STAT_BUSY = 8;
   localparam int STAT_MASTER = 9;
   localparam int STAT_FULL = 10;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_SHIFT = 2'h1,
      ST_DONE = 2'h3
   } asrp_state_t;
endpackage : asrp_pkg

// ===== logic/asrp_fifo.sv
`timescale 1ns/1ps
module asrp_fifo #(
   parameter int WIDTH = asrp_pkg::RESULT_BITS,
   parameter int DEPTH = asrp_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,                    // system clock
   input wire logic rst_i,                    // synchronous reset
   input wire logic in_valid_i,               // write request
   output logic in_ready_o,                   // room for a word
   input wire logic [WIDTH-1:0] in_data_i,    // write word
   output logic out_valid_o,                  // word available
   input wire logic out_ready_i,              // pop
   output logic [WIDTH-1:0] out_data_o,       // head word
   output logic [$clog2(DEPTH+1)-1:0] count_o // fill level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      begin : g_bad
         $error("asrp_fifo: depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = cnt_q != CW'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;
   assign count_o = cnt_q;
   // head read straight from storage, so a word pushed into an empty buffer is seen at once
   assign out_data_o = mem_q[rd_q];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= rd_q + AW'(1);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule : asrp_fifo

// ===== logic/asrp_edge.sv
`timescale 1ns/1ps
module asrp_edge (
   input wire logic clk_i,     // system clock
   input wire logic rst_i,     // synchronous reset
   input wire logic level_i,   // sampled external clock
   input wire logic falling_i, // select falling edge as active
   output logic prev_o,        // level one cycle earlier
   output logic active_o       // one-cycle pulse on the active edge
);
   logic prev_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prev_q <= 1'b0;
      end
      else
      begin
         prev_q <= level_i;
      end
   end

   assign prev_o = prev_q;
   assign active_o = falling_i ? (prev_q && !level_i) : (!prev_q && level_i);
endmodule : asrp_edge

// ===== logic/asrp_serial_port.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] modes 0-2 parallel pins, mode 3 serial
// [RULE_02] edge invert applies to data clocks
// [RULE_03] read-after-convert: shift result after conversion
// [RULE_04] read-during-convert: shift previous result meanwhile
// [RULE_05] slave forwards chain input after sixteen periods
// [RULE_06] result shifted MSB first, coding selectable
// [RULE_07] master: data stable across both clock edges
// [RULE_08] slave, invert low: update on rising edge
// [RULE_09] slave, invert high: update on falling edge
// [RULE_10] data clock pin direction follows clock source
// [RULE_11] sync polarity low: sync high while valid
// [RULE_12] sync polarity high: sync low while valid
// [RULE_13] clock source low master, high slave
// [RULE_14] divider slows master read-after-convert clock only
// [RULE_15] each frame carries one complete result
module asrp_serial_port #(
   parameter int RESULT_BITS = asrp_pkg::RESULT_BITS,
   parameter int FIFO_DEPTH = asrp_pkg::FIFO_DEPTH,
   parameter int CHAIN_DELAY = asrp_pkg::CHAIN_DELAY
) (
   input wire logic SYS_CLK_I,                      // 200 MHz clock
   input wire logic RESET_I,                        // synchronous reset, high
   input wire logic [1:0] MODE_I,                   // interface mode field
   input wire logic OUTPUT_CODING_SELECT_I,         // high: flip sign bit
   input wire logic [asrp_pkg::PINS-1:0] PAR_DATA_I, // parallel bus word
   input wire logic [RESULT_BITS-1:0] RESULT_I,     // conversion result
   input wire logic RESULT_VALID_I,                 // result offered
   output logic RESULT_READY_O,                     // result accepted
   input wire logic CONVERTING_I,                   // conversion in progress
   input wire logic CS_N_I,                         // chip select, low
   input wire logic [asrp_pkg::PINS-1:0] PIN_I,     // shared pin levels
   output logic [asrp_pkg::PINS-1:0] PIN_O,         // shared pin drive
   output logic [asrp_pkg::PINS-1:0] PIN_OE_O,      // shared pin enables
   input wire logic [3:0] REG_ADDR_I,               // register byte address
   input wire logic [31:0] REG_WDATA_I,             // write data
   input wire logic REG_WR_I,                       // write strobe
   input wire logic REG_RD_I,                       // read strobe
   output logic [31:0] REG_RDATA_O                  // read data, next cycle
);
   localparam int BW = $clog2(RESULT_BITS+1);
   localparam int CW = $clog2(FIFO_DEPTH+1);

   generate
      if (RESULT_BITS < 2 || CHAIN_DELAY < 2 || CW > 8 || RESULT_BITS > asrp_pkg::PINS)
      begin : g_bad
         $error("asrp_serial_port: unsupported parameter values");
      end
   endgenerate

   // ------------------------------------------------------------
   // pin decode
   // ------------------------------------------------------------
   logic serial_mode;
   logic slave_sel;
   logic sync_pol;
   logic clk_inv;
   logic rsel_chain;
   logic [1:0] div_sel;
   logic sclk_in;

   assign serial_mode = MODE_I == asrp_pkg::MODE_SERIAL;
   assign slave_sel = PIN_I[asrp_pkg::PIN_CLKSRC];
   assign sync_pol = PIN_I[asrp_pkg::PIN_SYNCPOL];
   assign clk_inv = PIN_I[asrp_pkg::PIN_INVCLK];
   assign rsel_chain = PIN_I[asrp_pkg::PIN_READ_SEL];
   assign div_sel = {PIN_I[asrp_pkg::PIN_DIV1], PIN_I[asrp_pkg::PIN_DIV0]};
   assign sclk_in = PIN_I[asrp_pkg::PIN_SCLK];

   // ------------------------------------------------------------
   // result buffer
   // ------------------------------------------------------------
   logic fifo_valid;
   logic [RESULT_BITS-1:0] fifo_data;
   logic [CW-1:0] fifo_count;
   logic load;
   logic pop;

   asrp_fifo #(
      .WIDTH(RESULT_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .in_valid_i(RESULT_VALID_I),
      .in_ready_o(RESULT_READY_O),
      .in_data_i(RESULT_I),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data),
      .count_o(fifo_count)
   );

   // ------------------------------------------------------------
   // slave clock edge detection
   // ------------------------------------------------------------
   logic sclk_prev;
   logic sclk_active;

   asrp_edge u_edge (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .level_i(sclk_in),
      .falling_i(clk_inv),
      .prev_o(sclk_prev),
      .active_o(sclk_active)
   );

   // ------------------------------------------------------------
   // control registers and frame state
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [15:0] frames_q;
   logic [31:0] rdata_q;
   logic [31:0] status_w;
   asrp_pkg::asrp_state_t state_q;
   logic master_q;
   logic cs_n_prev_q;
   logic [RESULT_BITS-1:0] sh_q;
   logic [CHAIN_DELAY-1:0] chain_q;
   logic [BW-1:0] bit_cnt_q;
   logic [1:0] phase_q;
   logic [10:0] qcnt_q;
   logic [10:0] quarter_len;
   logic [7:0] qlen8;
   logic apply_div;
   logic master_start;
   logic slave_start;
   logic quarter_tick;
   logic last_bit;
   logic frame_end_m;
   logic slave_edge;
   logic [RESULT_BITS-1:0] load_word;
   logic serial_bit;
   logic sclk_raw;
   logic sync_active;

   assign qlen8 = (ctrl_q[asrp_pkg::CTRL_QLEN_LSB +: 8] == 8'h00) ? 8'h01 : ctrl_q[asrp_pkg::CTRL_QLEN_LSB +: 8];
   assign apply_div = !slave_sel && !rsel_chain; // [RULE_14]
   assign quarter_len = {3'h0, qlen8} << (apply_div ? div_sel : 2'h0); // [RULE_14]

   // a low read select waits for the conversion to finish, so full throughput is lost
   assign master_start = serial_mode && !slave_sel && ctrl_q[asrp_pkg::CTRL_ENABLE] && fifo_valid
                         && (rsel_chain ? CONVERTING_I : !CONVERTING_I); // [RULE_03] [RULE_04]
   assign slave_start = serial_mode && slave_sel && cs_n_prev_q && !CS_N_I; // [RULE_13]
   assign load = (state_q == asrp_pkg::ST_IDLE) && (master_start || slave_start);
   assign pop = load && fifo_valid;

   // an empty buffer in slave mode shifts zeros rather than stalling the host
   assign load_word = fifo_valid ? (fifo_data ^ {OUTPUT_CODING_SELECT_I, {(RESULT_BITS-1){1'b0}}})
                                 : '0; // [RULE_06]

   assign quarter_tick = master_q && (state_q == asrp_pkg::ST_SHIFT) && (qcnt_q == quarter_len - 11'h001);
   assign last_bit = bit_cnt_q == BW'(RESULT_BITS-1);
   assign frame_end_m = quarter_tick && (phase_q == 2'h3) && last_bit; // [RULE_15]
   assign slave_edge = !master_q && (state_q == asrp_pkg::ST_SHIFT) && !CS_N_I && sclk_active; // [RULE_08] [RULE_09]

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         cs_n_prev_q <= 1'b1;
      end
      else
      begin
         cs_n_prev_q <= CS_N_I;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         state_q <= asrp_pkg::ST_IDLE;
         master_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            asrp_pkg::ST_IDLE:
            begin
               if (load)
               begin
                  state_q <= asrp_pkg::ST_SHIFT;
                  master_q <= master_start; // [RULE_13]
               end
            end
            asrp_pkg::ST_SHIFT:
            begin
               if ((master_q && frame_end_m) || (!master_q && CS_N_I) || !serial_mode)
               begin
                  state_q <= asrp_pkg::ST_DONE;
               end
            end
            asrp_pkg::ST_DONE:
            begin
               state_q <= asrp_pkg::ST_IDLE;
            end
            default:
            begin
               state_q <= asrp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // master timing: four quarter phases per bit, clock high in phases 1 and 2
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I || load || !master_q || state_q != asrp_pkg::ST_SHIFT)
      begin
         qcnt_q <= '0;
         phase_q <= 2'h0;
      end
      else if (quarter_tick)
      begin
         qcnt_q <= '0;
         phase_q <= phase_q + 2'h1;
      end
      else
      begin
         qcnt_q <= qcnt_q + 11'h001;
      end
   end

   // master data moves only at the middle of the low phase, clear of both edges; slave data moves on the active edge
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         sh_q <= '0;
         bit_cnt_q <= '0;
         chain_q <= '0;
      end
      else if (load)
      begin
         sh_q <= load_word; // [RULE_06]
         bit_cnt_q <= '0;
         chain_q <= '0;
      end
      else if (quarter_tick && phase_q == 2'h3 && !last_bit)
      begin
         sh_q <= {sh_q[RESULT_BITS-2:0], 1'b0}; // [RULE_06] [RULE_07]
         bit_cnt_q <= bit_cnt_q + BW'(1);
      end
      else if (slave_edge)
      begin
         sh_q <= {sh_q[RESULT_BITS-2:0], 1'b0}; // [RULE_08] [RULE_09]
         chain_q <= {chain_q[CHAIN_DELAY-2:0], rsel_chain}; // [RULE_05]
         if (bit_cnt_q != BW'(RESULT_BITS))
         begin
            bit_cnt_q <= bit_cnt_q + BW'(1);
         end
      end
   end

   // once the own word is out, the chained stream follows
   assign serial_bit = (!master_q && bit_cnt_q == BW'(RESULT_BITS)) ? chain_q[CHAIN_DELAY-1]
                                                                     : sh_q[RESULT_BITS-1]; // [RULE_05]
   assign sclk_raw = master_q && (state_q == asrp_pkg::ST_SHIFT) && (phase_q == 2'h1 || phase_q == 2'h2);
   assign sync_active = master_q && (state_q == asrp_pkg::ST_SHIFT); // [RULE_15]

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         PIN_O <= '0;
         PIN_OE_O <= '0;
      end
      else if (!serial_mode)
      begin
         PIN_O <= PAR_DATA_I; // [RULE_01]
         PIN_OE_O <= '1;
      end
      else
      begin
         PIN_O <= '0; // [RULE_01]
         PIN_OE_O <= '0; // [RULE_14]
         PIN_O[asrp_pkg::PIN_SERIAL_OUT] <= (state_q == asrp_pkg::ST_SHIFT) && serial_bit;
         PIN_OE_O[asrp_pkg::PIN_SERIAL_OUT] <= 1'b1;
         PIN_O[asrp_pkg::PIN_SCLK] <= sclk_raw ^ clk_inv; // [RULE_02]
         PIN_OE_O[asrp_pkg::PIN_SCLK] <= !slave_sel; // [RULE_10] [RULE_13]
         PIN_O[asrp_pkg::PIN_SYNC] <= sync_active ? !sync_pol : sync_pol; // [RULE_11] [RULE_12]
         PIN_OE_O[asrp_pkg::PIN_SYNC] <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   always_comb
   begin
      status_w = '0;
      status_w[CW-1:0] = fifo_count;
      status_w[asrp_pkg::STAT_BUSY] = state_q != asrp_pkg::ST_IDLE;
      status_w[asrp_pkg::STAT_MASTER] = master_q;
      status_w[asrp_pkg::STAT_FULL] = !RESULT_READY_O;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         ctrl_q <= asrp_pkg::CTRL_RESET;
      end
      else if (REG_WR_I && REG_ADDR_I == asrp_pkg::REG_CTRL)
      begin
         ctrl_q <= {16'h0000, REG_WDATA_I[15:8], 7'h00, REG_WDATA_I[0]};
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I)
      begin
         frames_q <= '0;
      end
      else if (state_q == asrp_pkg::ST_DONE)
      begin
         frames_q <= frames_q + 16'h0001;
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RESET_I || !REG_RD_I)
      begin
         rdata_q <= '0;
      end
      else
      begin
         case (REG_ADDR_I)
            asrp_pkg::REG_CTRL: rdata_q <= ctrl_q;
            asrp_pkg::REG_STATUS: rdata_q <= status_w;
            asrp_pkg::REG_FRAMES: rdata_q <= {16'h0000, frames_q};
            default: rdata_q <= '0;
         endcase
      end
   end

   assign REG_RDATA_O = rdata_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_parallel_pins;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      !serial_mode |=> (PIN_OE_O == '1) && (PIN_O == $past(PAR_DATA_I));
   endproperty
   a_parallel_pins: assert property (p_parallel_pins) else $error("parallel pins not driven"); // [RULE_01]

   property p_edge_select;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      slave_edge |-> (clk_inv ? (sclk_prev && !sclk_in) : (!sclk_prev && sclk_in));
   endproperty
   a_edge_select: assert property (p_edge_select) else $error("slave shift on wrong edge"); // [RULE_02]

   property p_after_convert;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      load && master_start && !rsel_chain |-> !CONVERTING_I;
   endproperty
   a_after_convert: assert property (p_after_convert) else $error("read started during conversion"); // [RULE_03]

   property p_during_convert;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      load && master_start && rsel_chain |-> CONVERTING_I ##1 (state_q == asrp_pkg::ST_SHIFT);
   endproperty
   a_during_convert: assert property (p_during_convert) else $error("read not during conversion"); // [RULE_04]

   property p_chain_capture;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      slave_edge && !load |=> chain_q[0] == $past(rsel_chain);
   endproperty
   a_chain_capture: assert property (p_chain_capture) else $error("chain input not captured"); // [RULE_05]

   property p_msb_first;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      quarter_tick && phase_q == 2'h3 && !last_bit |=> sh_q[RESULT_BITS-1] == $past(sh_q[RESULT_BITS-2]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("shift order wrong"); // [RULE_06]

   property p_master_stable;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      master_q && state_q == asrp_pkg::ST_SHIFT && $past(state_q) == asrp_pkg::ST_SHIFT && phase_q != 2'h0
      |-> $stable(sh_q);
   endproperty
   a_master_stable: assert property (p_master_stable) else $error("master data moved near an edge"); // [RULE_07]

   property p_slave_stable;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      !master_q && $past(state_q) == asrp_pkg::ST_SHIFT && !$past(slave_edge) && !$past(load) |-> $stable(sh_q);
   endproperty
   a_slave_stable: assert property (p_slave_stable) else $error("slave data moved off edge"); // [RULE_08] [RULE_09]

   property p_clock_dir;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      serial_mode |=> PIN_OE_O[asrp_pkg::PIN_SCLK] == !$past(slave_sel);
   endproperty
   a_clock_dir: assert property (p_clock_dir) else $error("data clock direction wrong"); // [RULE_10] [RULE_13]

   property p_sync_level;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      serial_mode && sync_active |=> PIN_O[asrp_pkg::PIN_SYNC] == !$past(sync_pol);
   endproperty
   a_sync_level: assert property (p_sync_level) else $error("frame sync level wrong"); // [RULE_11] [RULE_12]

   property p_divider_hiz;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      serial_mode |=> !PIN_OE_O[asrp_pkg::PIN_DIV0] && !PIN_OE_O[asrp_pkg::PIN_DIV1];
   endproperty
   a_divider_hiz: assert property (p_divider_hiz) else $error("divider pins driven"); // [RULE_14]

   property p_frame_length;
      @(posedge SYS_CLK_I) disable iff (RESET_I)
      $fell(state_q == asrp_pkg::ST_SHIFT) && $past(master_q) && $past(serial_mode)
      |-> $past(bit_cnt_q) == BW'(RESULT_BITS-1) && $past(phase_q) == 2'h3;
   endproperty
   a_frame_length: assert property (p_frame_length) else $error("master frame not full length"); // [RULE_15]
endmodule : asrp_serial_port

// ===== test/asrp_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: master capture and gated slave clock
// ------------------------------------------------------------
module asrp_host_model (
   input wire logic clk_i,        // system clock
   input wire logic [17:0] pin_i, // device pin drive
   input wire logic inv_i,        // clock edge invert
   input wire logic pol_i,        // frame sync polarity
   input wire logic clr_i,        // clear capture
   output logic sclk_o,           // host data clock
   output logic cs_n_o            // chip select, low
);
   logic raw = 1'b0;
   logic prev = 1'b0;
   logic [17:0] cap = '0;
   int nb = 0;
   int ns = 0;
   initial cs_n_o = 1'b1;
   // clock stands at its idle level outside frames
   assign sclk_o = raw ^ inv_i;
   always @(posedge clk_i)
   begin
      prev <= pin_i[11];
      if (clr_i)
      begin
         nb <= 0;
         ns <= 0;
      end
      else if (pin_i[12] == !pol_i)
      begin
         ns <= ns + 1;
         if (pin_i[11] != prev && pin_i[11] == !inv_i)
         begin
            cap <= {cap[16:0], pin_i[10]};
            nb <= nb + 1;
         end
      end
   end
   task automatic slave_read(input int n, output logic [35:0] w);
      w = '0;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < n; i++)
      begin
         // sample after the edge has settled the registered pin
         #1 w = {w[34:0], pin_i[10]};
         raw <= 1'b1;
         repeat (4) @(posedge clk_i);
         raw <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
      cs_n_o <= 1'b1;
   endtask : slave_read
endmodule : asrp_host_model

// ===== test/test_adc_serial_result_port.sv
`timescale 1ns/1ps
module test_adc_serial_result_port;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] mode = 2'h0;
   logic ocs = 1'b0;
   logic [17:0] par = '0;
   logic [17:0] res = '0;
   logic rv = 1'b0;
   logic conv = 1'b0;
   logic [1:0] div = 2'h0;
   logic src = 1'b0;
   logic pol = 1'b0;
   logic inv = 1'b0;
   logic p9 = 1'b0;
   logic clr = 1'b0;
   logic [3:0] addr = '0;
   logic [31:0] wd = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdat;
   logic [31:0] d;
   logic [35:0] w;
   logic [17:0] wv;
   logic [17:0] po;
   logic [17:0] oe;
   logic [17:0] pi;
   logic rdy;
   logic sclk;
   logic cs_n;
   logic [5:0] mt [3] = '{6'h00, 6'h1d, 6'h2a};
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   assign pi = {5'h0, 1'b0, sclk, 1'b0, p9, inv, pol, src, div, 4'h0};
   initial forever #2.5 clk = ~clk;
   asrp_serial_port asrp_serial_port_i (.SYS_CLK_I(clk), .RESET_I(rst), .MODE_I(mode),
      .OUTPUT_CODING_SELECT_I(ocs), .PAR_DATA_I(par), .RESULT_I(res), .RESULT_VALID_I(rv),
      .RESULT_READY_O(rdy), .CONVERTING_I(conv), .CS_N_I(cs_n), .PIN_I(pi), .PIN_O(po),
      .PIN_OE_O(oe), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdat));
   asrp_host_model asrp_host_model_i (.clk_i(clk), .pin_i(po), .inv_i(inv), .pol_i(pol),
      .clr_i(clr), .sclk_o(sclk), .cs_n_o(cs_n));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
   endtask : rreg
   task automatic push(input logic [17:0] v);
      @(posedge clk);
      res <= v;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
   endtask : push
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // ------------------------------------------------------------
   // hang guard, well above the expected run length
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         fails++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      chk("reset enables", oe, 18'h0);
      chk("reset ready", rdy, 1'b1);
      rst <= 1'b0;
      rreg(4'h0, d);
      chk("ctrl reset", d, 32'h0000_0101);
      rreg(4'hc, d);
      chk("unmapped read", d, 32'h0);
      for (int m = 0; m < 3; m++)
      begin
         mode <= 2'(m);
         par <= 18'h15a5a ^ 18'(m);
         repeat (3) @(posedge clk);
         chk("parallel pins", po, 18'h15a5a ^ 18'(m));
         chk("parallel enables", oe, 18'h3ffff);
      end
      $display("parallel test done");
      // the read is held off until the conversion state allows it
      for (int k = 0; k < 3; k++)
      begin
         {p9, inv, pol, ocs, div} <= mt[k];
         src <= 1'b0;
         mode <= 2'h3;
         conv <= ~mt[k][5];
         wv = 18'h2d3a5 + 18'(k);
         @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         push(wv);
         repeat (30) @(posedge clk);
         chk("held bits", 36'(asrp_host_model_i.nb), 36'h0);
         conv <= mt[k][5];
         repeat (200) @(posedge clk);
         chk("frame bits", 36'(asrp_host_model_i.nb), 36'd18);
         chk("frame word", asrp_host_model_i.cap, wv ^ {mt[k][2], 17'h0});
         chk("sync length", 36'(asrp_host_model_i.ns),
            36'(mt[k][5] ? 72 : 72 << mt[k][1:0]));
         chk("clock drive", oe[11], 1'b1);
      end
      $display("master test done");
      for (int i = 0; i < 2; i++)
      begin
         src <= 1'b1;
         p9 <= 1'b1;
         ocs <= 1'b0;
         inv <= i[0];
         repeat (4) @(posedge clk);
         wv = 18'h1b2c4 + 18'(i);
         push(wv);
         asrp_host_model_i.slave_read(20, w);
         chk("slave word", w, {16'h0, wv, 2'b11});
         chk("clock input", oe[11], 1'b0);
      end
      $display("slave test done");
      wreg(4'h0, 32'h0000_0100);
      {src, p9, conv, div} <= 5'h0;
      for (int i = 0; i < 33; i++)
         push(18'(i));
      rreg(4'h4, d);
      chk("full count", d[10:0], 11'h420);
      chk("full ready", rdy, 1'b0);
      rreg(4'h8, d);
      chk("frame count", d, 32'h5);
      wreg(4'h0, 32'h0000_0101);
      for (int t = 0; t < 100 && d[5:0] != 6'h0; t++)
      begin
         repeat (100) @(posedge clk);
         rreg(4'h4, d);
      end
      chk("drained count", d[5:0], 6'h0);
      $display("fifo test done");
      wrap_up();
   end
endmodule : test_adc_serial_result_port
